// ==== pkg/adcc_pkg.sv ====
// Notes on behaviour
// - selector-out bit routes selector/converter to pins
// - no temperature sensor while selector-out set
// - selector-out limits channels to 10-13, pair 10/11
// - selector-out keeps channel and input path enabled
// - acquisition lasts three converter clock cycles
// - mode bit: 0 single-ended, 1 differential
// - busy clear stops prescaler and converter clock
// - setting busy starts conversion with current settings
// - completion clears busy, powers converter down
// - write 0 aborts, write 1 restarts, back to back
// - inputs gated off when idle unless routed/amplified
// - high register holds result bits 9..2
// - hardware writes results; software writable; retained
// - low register bits 5..0 read zero
// - result registers have no reset value
// - control: channel 7:4, mode, selout, prescale, busy
// - reset clears control register entirely
// - selector-out clear: all seven channels selectable single-ended; differential mode excludes the temperature sensor
package adcc_pkg;

    // ---------------------------------------------------------
    // register map
    // ---------------------------------------------------------
    localparam logic [11:0] OFS_CONTROL = 12'h000;
    localparam logic [11:0] OFS_RES_HIGH = 12'h004;
    localparam logic [11:0] OFS_RES_LOW = 12'h008;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // ---------------------------------------------------------
    // control field positions
    // ---------------------------------------------------------
    localparam int POS_BUSY = 0;
    localparam int POS_PRESCALE = 1;
    localparam int POS_SELOUT = 2;
    localparam int POS_MODE = 3;
    localparam int POS_CHAN = 4;
    localparam int POS_LOW_RES = 6;

    // ---------------------------------------------------------
    // channels and timing
    // ---------------------------------------------------------
    localparam logic [3:0] CH_CODE_TEMP = 4'h7;
    localparam logic [3:0] CH_CODE_BASE = 4'ha;
    localparam int NUM_CHAN = 7;
    localparam int RESULT_BITS = 10;
    localparam int ACQ_CYCLES = 3;
    localparam int PRESCALE_SLOW = 16;

    typedef struct packed {
        logic [3:0] chan;
        logic diff_mode;
        logic sel_out;
        logic prescale;
        logic busy;
    } adcc_ctrl_type;

    typedef struct packed {
        logic sel_to_pin14;
        logic adc_from_pin15;
        logic sel_gate_en;
        logic adc_path_en;
        logic diff_mode;
    } adcc_route_type;

endpackage

// ==== core/adcc_top.sv ====
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module adcc_top #(
    parameter int PRESCALE_DIV = adcc_pkg::PRESCALE_SLOW,
    parameter int ACQ_TICKS = adcc_pkg::ACQ_CYCLES
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic NRST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // analog side
    input wire logic AMP_ENABLED,
    input wire logic COMP_HIGH,
    output logic ADC_CLK_ON,
    output logic SAMPLE_TRACK,
    output logic [9:0] TRIAL_CODE,
    output logic [6:0] CHAN_POS,
    output logic [6:0] CHAN_NEG,
    output adcc_pkg::adcc_route_type ROUTE
);
    import adcc_pkg::*;

    initial begin
        if (PRESCALE_DIV < 2 || PRESCALE_DIV > 256 ||
            (PRESCALE_DIV & (PRESCALE_DIV - 1)) != 0) begin
            $error("PRESCALE_DIV must be a power of two, 2..256");
        end
        if (ACQ_TICKS < 1 || ACQ_TICKS > 15) begin
            $error("ACQ_TICKS must be 1..15");
        end
    end

    typedef enum logic [1:0] {S_IDLE, S_ACQUIRE, S_CONVERT} adcc_state_type;

    // ---------------------------------------------------------
    // reset release
    // ---------------------------------------------------------
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // ---------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    adcc_ctrl_type ctrl_q;
    adcc_ctrl_type ctrl_d;
    adcc_ctrl_type cfg_q;
    logic [7:0] res_high_q;
    logic [1:0] res_low_q;

    wire access = PSEL && PENABLE && !pready_q;
    wire done_acc = PSEL && PENABLE && pready_q;
    wire hit_ctrl = (PADDR == OFS_CONTROL);
    wire hit_high = (PADDR == OFS_RES_HIGH);
    wire hit_low = (PADDR == OFS_RES_LOW);
    wire mapped = hit_ctrl || hit_high || hit_low;
    wire ctrl_wr = done_acc && PWRITE && hit_ctrl;
    wire high_wr = done_acc && PWRITE && hit_high;
    wire low_wr = done_acc && PWRITE && hit_low;
    wire [7:0] low_view = {res_low_q, 6'h00};
    wire [7:0] rd_byte = hit_ctrl ? ctrl_q :
                         hit_high ? res_high_q :
                         hit_low ? low_view : 8'h00;

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access;
            pslverr_q <= access && !mapped;
            prdata_q <= (access && !PWRITE) ? {24'h00_0000, rd_byte} :
                        32'h0000_0000;
        end
    end

    // ---------------------------------------------------------
    // prescaler and converter clock
    // ---------------------------------------------------------
    logic [7:0] presc_q;
    adcc_state_type state_q;
    adcc_state_type state_d;
    logic [3:0] step_q;
    logic [3:0] bit_q;
    logic [9:0] sar_q;

    wire busy = ctrl_q.busy;
    wire [7:0] presc_top = 8'(PRESCALE_DIV - 1);
    wire tick = busy && (!cfg_q.prescale || presc_q == presc_top);

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            presc_q <= 8'h00;
        end else if (!busy || !cfg_q.prescale || tick) begin
            presc_q <= 8'h00;
        end else begin
            presc_q <= presc_q + 8'h01;
        end
    end

    // ---------------------------------------------------------
    // conversion sequencer
    // ---------------------------------------------------------
    wire wr_busy = PWDATA[POS_BUSY];
    wire [9:0] bit_mask = 10'h001 << bit_q;
    wire [9:0] sar_keep = COMP_HIGH ? sar_q : (sar_q & ~bit_mask);
    wire last_bit = (bit_q == 4'h0);
    wire done = (state_q == S_CONVERT) && tick && last_bit && busy;
    // a start is a 0-to-1 write of busy; completion in the same cycle
    // frees the sequencer, so the write still starts
    wire start = ctrl_wr && wr_busy && (!busy || done);
    wire abort = ctrl_wr && !wr_busy;
    wire acq_end = (step_q == 4'(ACQ_TICKS - 1));

    always_comb begin
        state_d = state_q;
        if (start) begin
            state_d = S_ACQUIRE;
        end else if (abort || done) begin
            state_d = S_IDLE;
        end else if (state_q == S_ACQUIRE && tick && acq_end) begin
            state_d = S_CONVERT;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            step_q <= 4'h0;
            bit_q <= 4'h0;
            sar_q <= 10'h000;
        end else begin
            state_q <= state_d;
            if (start) begin
                step_q <= 4'h0;
                bit_q <= 4'(RESULT_BITS - 1);
                sar_q <= 10'h200;
            end else if (state_q == S_ACQUIRE && tick) begin
                step_q <= step_q + 4'h1;
            end else if (state_q == S_CONVERT && tick && !last_bit) begin
                bit_q <= bit_q - 4'h1;
                sar_q <= sar_keep | (bit_mask >> 1);
            end
        end
    end

    // ---------------------------------------------------------
    // control register
    // ---------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrl_wr) begin
            ctrl_d = adcc_ctrl_type'(PWDATA[7:0]);
        end else if (done) begin
            ctrl_d.busy = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= adcc_ctrl_type'(CONTROL_RESET);
            cfg_q <= adcc_ctrl_type'(CONTROL_RESET);
        end else begin
            ctrl_q <= ctrl_d;
            if (start) begin
                cfg_q <= adcc_ctrl_type'(PWDATA[7:0]);
            end
        end
    end

    // ---------------------------------------------------------
    // result registers, no reset on purpose
    // ---------------------------------------------------------
    wire [9:0] result = sar_keep;

    always_ff @(posedge SYS_CLK) begin
        if (done) begin
            res_high_q <= result[9:2];
            res_low_q <= result[1:0];
        end else begin
            if (high_wr) begin
                res_high_q <= PWDATA[7:0];
            end
            if (low_wr) begin
                res_low_q <= PWDATA[POS_LOW_RES +: 2];
            end
        end
    end

    // ---------------------------------------------------------
    // channel selection and routing
    // ---------------------------------------------------------
    // settings in force: snapshot while converting, live while idle
    adcc_ctrl_type act;
    assign act = busy ? cfg_q : ctrl_q;
    wire gate_en = busy || act.sel_out || AMP_ENABLED;

    logic [6:0] pos_d;
    logic [6:0] neg_d;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi = gi + 1) begin : g_chan
            localparam logic [3:0] CODE = (gi == 0) ? CH_CODE_TEMP :
                                          4'(CH_CODE_BASE + gi - 1);
            localparam logic [3:0] PARTNER = CODE ^ 4'h1;
            wire allow_se = (gi == 0) ? !act.sel_out :
                            (!act.sel_out || gi <= 4);
            wire allow_df = (gi != 0) &&
                            (!act.sel_out || gi <= 2);
            wire allow = act.diff_mode ? allow_df : allow_se;
            assign pos_d[gi] = gate_en && allow && (act.chan == CODE);
            assign neg_d[gi] = gate_en && act.diff_mode && allow_df &&
                               (act.chan == PARTNER);
        end
    endgenerate

    adcc_route_type route_d;
    always_comb begin
        route_d.sel_to_pin14 = act.sel_out;
        route_d.adc_from_pin15 = act.sel_out;
        route_d.sel_gate_en = gate_en;
        route_d.adc_path_en = gate_en;
        route_d.diff_mode = act.diff_mode;
    end

    // ---------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------
    logic track_q;
    logic clk_on_q;
    logic [6:0] pos_q;
    logic [6:0] neg_q;
    adcc_route_type route_q;

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            track_q <= 1'b0;
            clk_on_q <= 1'b0;
            pos_q <= 7'h00;
            neg_q <= 7'h00;
            route_q <= '0;
        end else begin
            track_q <= (state_d == S_ACQUIRE);
            clk_on_q <= ctrl_d.busy;
            pos_q <= pos_d;
            neg_q <= neg_d;
            route_q <= route_d;
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign ADC_CLK_ON = clk_on_q;
    assign SAMPLE_TRACK = track_q;
    assign TRIAL_CODE = sar_q;
    assign CHAN_POS = pos_q;
    assign CHAN_NEG = neg_q;
    assign ROUTE = route_q;

    // ---------------------------------------------------------
    // assertions
    // ---------------------------------------------------------
    wire start_div1 = start && !PWDATA[POS_PRESCALE];
    wire res_wr = high_wr || low_wr;
    logic res_seen_q;

    // result registers hold no defined value until their first load
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            res_seen_q <= 1'b0;
        end else if (done || high_wr) begin
            res_seen_q <= 1'b1;
        end
    end

    sequence s_setup;
        PSEL && !PENABLE;
    endsequence

    sequence s_answer;
        !pready_q ##1 pready_q;
    endsequence

    a_apb_ready_two: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        s_setup |=> s_answer)
        else $error("apb answer not in second access cycle");

    a_busy_clear_done: assert property (@(posedge SYS_CLK)
        disable iff (!rst_n) (done && !ctrl_wr) |=> !ctrl_q.busy && !ADC_CLK_ON)
        else $error("busy still set after completion");

    a_acq_three_ticks: assert property (@(posedge SYS_CLK)
        disable iff (!rst_n) start_div1 |=> SAMPLE_TRACK [*3] ##1 !SAMPLE_TRACK)
        else $error("acquisition not three converter cycles");

    a_selout_keeps_gate: assert property (@(posedge SYS_CLK)
        disable iff (!rst_n) act.sel_out |=> ROUTE.sel_gate_en &&
        ROUTE.adc_path_en && ROUTE.sel_to_pin14)
        else $error("routed path not held enabled");

    a_idle_gate_off: assert property (@(posedge SYS_CLK)
        disable iff (!rst_n) (!busy && !ctrl_q.sel_out && !AMP_ENABLED)
        |=> !ROUTE.sel_gate_en && CHAN_POS == 7'h00)
        else $error("inputs not gated off while idle");

    a_prescale_stopped: assert property (@(posedge SYS_CLK)
        disable iff (!rst_n) !busy |=> presc_q == 8'h00)
        else $error("prescaler runs while idle");

    a_div16_spacing: assert property (@(posedge SYS_CLK)
        disable iff (!rst_n) (tick && cfg_q.prescale && !ctrl_wr)
        |=> (!tick) [*8])
        else $error("slow prescaler ticks too often");

    a_low_reads_zero: assert property (@(posedge SYS_CLK)
        disable iff (!rst_n) (access && !PWRITE && hit_low)
        |=> PRDATA[5:0] == 6'h00 && PRDATA[7:6] == $past(res_low_q))
        else $error("low result reads wrong");

    a_result_retained: assert property (@(posedge SYS_CLK)
        disable iff (!rst_n) (res_seen_q && !done && !res_wr)
        |=> $stable(res_high_q))
        else $error("result changed without cause");

    a_no_temp_selout: assert property (@(posedge SYS_CLK)
        disable iff (!rst_n) act.sel_out |=> !CHAN_POS[0])
        else $error("temperature sensor offered with selector out");

endmodule
`default_nettype wire

// ==== verification/tb_adcc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// bench for the converter control block
// ---------------------------------------------
module tb_adcc_top;
    import adcc_pkg::*;
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic [31:0] rdata;
        logic err;
    } adcc_row_type;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic amp_enabled = 1'b0;
    logic comp_high;
    logic adc_clk_on;
    logic sample_track;
    logic [9:0] trial_code;
    logic [6:0] chan_pos;
    logic [6:0] chan_neg;
    adcc_route_type route;
    logic [9:0] vin = 10'h000;
    logic [31:0] rd;
    logic er;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    adcc_row_type rows [5] = '{
        '{OFS_CONTROL, 8'ha4, 32'h0000_00a4, 1'b0},
        '{OFS_CONTROL, 8'hf8, 32'h0000_00f8, 1'b0},
        '{OFS_RES_HIGH, 8'h5a, 32'h0000_005a, 1'b0},
        '{OFS_RES_LOW, 8'hff, 32'h0000_00c0, 1'b0},
        '{12'h00c, 8'h55, 32'h0000_0000, 1'b1}
    };

    adcc_top u_adcc_top (
        .SYS_CLK(sys_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .AMP_ENABLED(amp_enabled),
        .COMP_HIGH(comp_high), .ADC_CLK_ON(adc_clk_on),
        .SAMPLE_TRACK(sample_track), .TRIAL_CODE(trial_code),
        .CHAN_POS(chan_pos), .CHAN_NEG(chan_neg), .ROUTE(route)
    );

    // comparator of the analog side
    assign comp_high = (vin >= trial_code);

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors = num_errors + 1;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [7:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (n == 16) check(32'h1, 32'h0);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_done();
        int n;
        for (n = 0; n < 400; n++) begin
            @(posedge sys_clk);
            if (adc_clk_on === 1'b0) break;
        end
        check({31'h0, adc_clk_on}, 32'h0);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        apb(1'b0, OFS_CONTROL, 8'h00);
        check(rd, 32'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            apb(1'b1, rows[i].addr, rows[i].wdata);
            apb(1'b0, rows[i].addr, 8'h00);
            check(rd, rows[i].rdata);
            check({31'h0, er}, {31'h0, rows[i].err});
        end
        $display("test registers done");
        apb(1'b1, OFS_CONTROL, 8'ha4);
        repeat (3) @(posedge sys_clk);
        check({28'h0, route[4:1]}, 32'hf);
        check({25'h0, chan_pos}, 32'h02);
        apb(1'b1, OFS_CONTROL, 8'h74);
        repeat (3) @(posedge sys_clk);
        check({31'h0, chan_pos[0]}, 32'h0);
        apb(1'b1, OFS_CONTROL, 8'ha0);
        repeat (3) @(posedge sys_clk);
        check({30'h0, route[2:1]}, 32'h0);
        amp_enabled <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check({30'h0, route[2:1]}, 32'h3);
        amp_enabled <= 1'b0;
        $display("test routing done");
        vin <= 10'h2d7;
        apb(1'b1, OFS_CONTROL, 8'ha1);
        repeat (2) @(posedge sys_clk);
        check({31'h0, adc_clk_on}, 32'h1);
        check({31'h0, sample_track}, 32'h1);
        wait_done();
        apb(1'b0, OFS_RES_HIGH, 8'h00);
        check(rd, 32'h0000_00b5);
        apb(1'b0, OFS_RES_LOW, 8'h00);
        check(rd, 32'h0000_00c0);
        apb(1'b0, OFS_CONTROL, 8'h00);
        check(rd, 32'h0000_00a0);
        $display("test fast conversion done");
        vin <= 10'h155;
        apb(1'b1, OFS_CONTROL, 8'hcb);
        repeat (20) @(posedge sys_clk);
        check({31'h0, adc_clk_on}, 32'h1);
        check({25'h0, chan_pos}, 32'h08);
        check({25'h0, chan_neg}, 32'h10);
        check({31'h0, route.diff_mode}, 32'h1);
        apb(1'b1, OFS_CONTROL, 8'hca);
        apb(1'b1, OFS_CONTROL, 8'hcb);
        apb(1'b1, OFS_CONTROL, 8'hca);
        repeat (2) @(posedge sys_clk);
        check({31'h0, adc_clk_on}, 32'h0);
        apb(1'b0, OFS_RES_HIGH, 8'h00);
        check(rd, 32'h0000_00b5);
        apb(1'b1, OFS_CONTROL, 8'hcb);
        wait_done();
        apb(1'b0, OFS_RES_HIGH, 8'h00);
        check(rd, 32'h0000_0055);
        apb(1'b0, OFS_RES_LOW, 8'h00);
        check(rd, 32'h0000_0040);
        $display("test abort and restart done");
        vin <= 10'h3ff;
        apb(1'b1, OFS_CONTROL, 8'ha4);
        repeat (8) @(posedge sys_clk);
        apb(1'b1, OFS_CONTROL, 8'ha5);
        repeat (2) @(posedge sys_clk);
        check({28'h0, route[4:1]}, 32'hf);
        check({25'h0, chan_pos}, 32'h02);
        wait_done();
        apb(1'b0, OFS_RES_HIGH, 8'h00);
        check(rd, 32'h0000_00ff);
        apb(1'b0, OFS_RES_LOW, 8'h00);
        check(rd, 32'h0000_00c0);
        $display("test routed conversion done");
        give_verdict();
    end
endmodule
`default_nettype wire
